// ===== rtl/cap_consts.svh
// constants for the closed-loop axis positioner: offsets, fields, timing
// assumes a 50 MHz clock and 12-bit converter words on the same clock
`ifndef CAP_CONSTS_SVH
`define CAP_CONSTS_SVH
`define CAP_ADC_W 12
`define CAP_ADC_LO 12'h333
`define CAP_ADC_BRK 12'h199
`define CAP_CLK_HZ 50000000
`define CAP_CLK_NS 20
`define CAP_SSI_BAUD 150000
`define CAP_SSI_HALF (`CAP_CLK_HZ / `CAP_SSI_BAUD / 2)
`define CAP_CTRL_NS 250000
`define CAP_CTRL_CYC (`CAP_CTRL_NS / `CAP_CLK_NS)
`define CAP_OFF_CTRL 8'h00
`define CAP_OFF_WIN 8'h04
`define CAP_OFF_ESTR 8'h08
`define CAP_OFF_JOGV 8'h0C
`define CAP_OFF_FVAL 8'h10
`define CAP_OFF_SSI 8'h14
`define CAP_OFF_GAIN 8'h18
`define CAP_OFF_STRK 8'h1C
`define CAP_OFF_BRK 8'h20
`define CAP_OFF_STAT 8'h24
`define CAP_OFF_POS 8'h28
`define CAP_OFF_DEM 8'h2C
`define CAP_B_SRC_AN 0
`define CAP_B_OUT_CUR 1
`define CAP_B_OUT_INV 2
`define CAP_B_PROF 3
`define CAP_F_CURVE 5:4
`define CAP_B_FLT_EN 6
`define CAP_B_CMD_CUR 7
`define CAP_B_SPD_CUR 8
`define CAP_B_FB_CUR 9
`define CAP_F_LEN 4:0
`define CAP_B_GRAY 8
`define CAP_F_RES 23:16
`define CAP_F_GAIN 7:0
`define CAP_F_GSH 11:8
`define CAP_F_FSH 19:16
`define CAP_F_MSH 28:24
`define CAP_CURVE_LIN 2'h0
`define CAP_CURVE_X3 2'h1
`define CAP_CURVE_X5 2'h2
`define CAP_RST_CTRL 32'h0000_0010
`define CAP_RST_WIN 32'h0000_0064
`define CAP_RST_ESTR 32'h0000_03E8
`define CAP_RST_JOGV 32'h0000_1000
`define CAP_RST_FVAL 32'h0000_0000
`define CAP_RST_SSI 32'h0001_0118
`define CAP_RST_GAIN 32'h0802_0410
`define CAP_RST_STRK 32'h0001_86A0
`define CAP_RST_BRK 32'h0000_2710
`endif

// ===== rtl/cap_pkg.sv
// types shared by the axis positioner
// assumes cap_consts.svh on the include path
`default_nettype none
`include "cap_consts.svh"
package cap_pkg;
	typedef enum {ST_OFF, ST_HOLD, ST_JOG, ST_RUN} cap_state_t;
	typedef enum {SSI_IDLE, SSI_LOW, SSI_HIGH} cap_ssi_t;
	typedef struct packed {
		logic enable;
		logic start;
		logic jog_pos;
		logic jog_neg;
	} cap_sw_t;
	typedef struct packed {
		logic [`CAP_ADC_W-1:0] pos_cmd;
		logic [`CAP_ADC_W-1:0] speed_cmd;
		logic [`CAP_ADC_W-1:0] fb;
	} cap_adc_t;
	typedef struct packed {
		logic [15:0] dac;
		logic [15:0] monitor;
		logic current;
		logic enable;
	} cap_aout_t;
endpackage
`default_nettype wire

// ===== rtl/cap_axis_top.sv
// closed-loop axis positioner with serial sensor master and wishbone regs
// assumes converter words on clk_i; switch pins and sensor data are async
`timescale 1ns/1ps
`default_nettype none
`include "cap_consts.svh"
module cap_axis_top #(
	parameter int CTRL_CYC = `CAP_CTRL_CYC,
	parameter int POS_W = 24
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// switching inputs and converter words
	input wire cap_pkg::cap_sw_t sw_i,
	input wire cap_pkg::cap_adc_t adc_i,
	// serial sensor link
	output logic ssi_clk_o,
	input wire logic ssi_dat_i,
	// analogue outputs and status
	output cap_pkg::cap_aout_t aout_o,
	output logic ready_o,
	output logic inpos_o
);
	import cap_pkg::*;
	localparam int EW = POS_W + 1;
	localparam int PW = EW + 12;
	localparam int AW = `CAP_ADC_W;

	// byte-lane merge for wishbone writes
	function automatic logic [31:0] wmask(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	// converter word to 0..full fraction, 4-20 mA offset removed
	function automatic logic [AW-1:0] in_frac(input logic [AW-1:0] a,
		input logic cur);
		logic [AW+2:0] t;
		t = '0;
		if (!cur)
			return a;
		if (a < `CAP_ADC_LO)
			return '0;
		t = (AW+3)'(a - `CAP_ADC_LO) * (AW+3)'(5);
		return AW'(t >> 2);
	endfunction

	// fraction of full scale times stroke length
	function automatic logic [POS_W-1:0] to_pos(input logic [AW-1:0] f,
		input logic [POS_W-1:0] s);
		logic [POS_W+AW-1:0] p;
		p = (POS_W+AW)'(f) * (POS_W+AW)'(s);
		return POS_W'(p >> AW);
	endfunction

	// gray to binary
	function automatic logic [31:0] gray2bin(input logic [31:0] g);
		logic [31:0] b;
		b = g;
		for (int i = 30; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	// two-flop synchronisers for pins
	cap_sw_t sw_m_r, sw_s_r;
	logic dat_m_r, dat_s_r;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sw_m_r <= '0;
			sw_s_r <= '0;
			dat_m_r <= 1'b0;
			dat_s_r <= 1'b0;
		end
		else
		begin
			sw_m_r <= sw_i;
			sw_s_r <= sw_m_r;
			dat_m_r <= ssi_dat_i;
			dat_s_r <= dat_m_r;
		end
	end

	// register file
	logic [31:0] ctrl_r, win_r, estr_r, jogv_r, fval_r, ssi_r, gain_r;
	logic [31:0] strk_r, brk_r;
	logic ack_r, wb_wr;
	assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_r <= `CAP_RST_CTRL;
			win_r <= `CAP_RST_WIN;
			estr_r <= `CAP_RST_ESTR;
			jogv_r <= `CAP_RST_JOGV;
			fval_r <= `CAP_RST_FVAL;
			ssi_r <= `CAP_RST_SSI;
			gain_r <= `CAP_RST_GAIN;
			strk_r <= `CAP_RST_STRK;
			brk_r <= `CAP_RST_BRK;
		end
		else if (wb_wr)
		begin
			case (wb_adr_i)
				`CAP_OFF_CTRL: ctrl_r <= wmask(ctrl_r, wb_dat_i, wb_sel_i);
				`CAP_OFF_WIN: win_r <= wmask(win_r, wb_dat_i, wb_sel_i);
				`CAP_OFF_ESTR: estr_r <= wmask(estr_r, wb_dat_i, wb_sel_i);
				`CAP_OFF_JOGV: jogv_r <= wmask(jogv_r, wb_dat_i, wb_sel_i);
				`CAP_OFF_FVAL: fval_r <= wmask(fval_r, wb_dat_i, wb_sel_i);
				`CAP_OFF_SSI: ssi_r <= wmask(ssi_r, wb_dat_i, wb_sel_i);
				`CAP_OFF_GAIN: gain_r <= wmask(gain_r, wb_dat_i, wb_sel_i);
				`CAP_OFF_STRK: strk_r <= wmask(strk_r, wb_dat_i, wb_sel_i);
				`CAP_OFF_BRK: brk_r <= wmask(brk_r, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	// control period tick
	logic [15:0] tick_cnt_r;
	logic tick;
	assign tick = (tick_cnt_r == 16'(CTRL_CYC - 1));
	always_ff @(posedge clk_i)
	begin
		if (rst_i || tick)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + 16'h0001;
	end

	// serial sensor master: one frame per control period
	cap_ssi_t ssi_st_r;
	logic [7:0] half_r;
	logic [4:0] nb_r;
	logic [31:0] shf_r;
	logic [POS_W-1:0] ssi_pos_r;
	logic ssi_err_r, half_end;
	assign half_end = (half_r == 8'(`CAP_SSI_HALF - 1));
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ssi_st_r <= SSI_IDLE;
			half_r <= '0;
			nb_r <= '0;
			shf_r <= '0;
			ssi_pos_r <= '0;
			ssi_err_r <= 1'b0;
		end
		else
		begin
			half_r <= (ssi_st_r == SSI_IDLE || half_end) ? 8'h00 :
				half_r + 8'h01;
			case (ssi_st_r)
				SSI_IDLE:
					if (tick)
					begin
						ssi_st_r <= SSI_LOW;
						nb_r <= '0;
						shf_r <= '0;
						ssi_err_r <= ~dat_s_r;
					end
				SSI_LOW:
					if (half_end)
						ssi_st_r <= SSI_HIGH;
				SSI_HIGH:
					if (half_end && nb_r == ssi_r[`CAP_F_LEN])
					begin
						ssi_st_r <= SSI_IDLE;
						ssi_err_r <= ssi_err_r | dat_s_r;
						ssi_pos_r <= POS_W'((ssi_r[`CAP_B_GRAY] ?
							gray2bin(shf_r) : shf_r) *
							32'(ssi_r[`CAP_F_RES]));
					end
					else if (half_end)
					begin
						ssi_st_r <= SSI_LOW;
						nb_r <= nb_r + 5'h01;
						shf_r <= {shf_r[30:0], dat_s_r};
					end
				default: ssi_st_r <= SSI_IDLE;
			endcase
		end
	end
	assign ssi_clk_o = (ssi_st_r != SSI_LOW);

	// scaled analogue inputs and error detection
	logic [AW-1:0] cmd_f, spd_f, fb_f;
	logic [POS_W-1:0] cmd_pos, fb_pos;
	logic cmd_brk, fb_brk;
	assign cmd_f = in_frac(adc_i.pos_cmd, ctrl_r[`CAP_B_CMD_CUR]);
	assign spd_f = in_frac(adc_i.speed_cmd, ctrl_r[`CAP_B_SPD_CUR]);
	assign fb_f = in_frac(adc_i.fb, ctrl_r[`CAP_B_FB_CUR]);
	assign cmd_pos = to_pos(cmd_f, strk_r[POS_W-1:0]);
	assign fb_pos = to_pos(fb_f, strk_r[POS_W-1:0]);
	assign cmd_brk = (ctrl_r[`CAP_B_CMD_CUR] &&
		adc_i.pos_cmd < `CAP_ADC_BRK) || (ctrl_r[`CAP_B_SPD_CUR] &&
		adc_i.speed_cmd < `CAP_ADC_BRK);
	assign fb_brk = ctrl_r[`CAP_B_FB_CUR] && adc_i.fb < `CAP_ADC_BRK;

	// per-period sampling of actual position and errors
	logic [POS_W-1:0] act_r, tgt_r;
	logic sens_err_r, cmd_err_r;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			act_r <= '0;
			sens_err_r <= 1'b0;
			cmd_err_r <= 1'b0;
		end
		else if (tick)
		begin
			act_r <= ctrl_r[`CAP_B_SRC_AN] ? fb_pos : ssi_pos_r;
			sens_err_r <= ctrl_r[`CAP_B_SRC_AN] ? fb_brk : ssi_err_r;
			cmd_err_r <= cmd_brk;
		end
	end

	// position error and controller law
	logic signed [EW-1:0] err, cerr;
	logic [EW-1:0] abs_err, abs_cerr;
	logic signed [PW-1:0] prod;
	logic signed [15:0] ctl, lim, raw;
	logic [3:0] mult;
	assign err = $signed({1'b0, tgt_r}) - $signed({1'b0, act_r});
	assign cerr = $signed({1'b0, cmd_pos}) - $signed({1'b0, act_r});
	assign abs_err = err[EW-1] ? EW'(-err) : EW'(err);
	assign abs_cerr = cerr[EW-1] ? EW'(-cerr) : EW'(cerr);
	assign lim = $signed({1'b0, spd_f, 3'h0});

	// gain boost inside braking zone per curve, with the profile bit clear
	always_comb
	begin
		mult = 4'h1;
		if (!ctrl_r[`CAP_B_PROF] && abs_err < EW'(brk_r))
			case (ctrl_r[`CAP_F_CURVE])
				`CAP_CURVE_X3: mult = 4'h3;
				`CAP_CURVE_X5: mult = 4'h5;
				default: mult = 4'h1;
			endcase
	end

	// proportional term, saturated, and speed limited with the profile bit clear
	always_comb
	begin
		prod = (PW'(err) * $signed({1'b0, gain_r[`CAP_F_GAIN]}) *
			$signed({1'b0, mult})) >>> gain_r[`CAP_F_GSH];
		if (prod > PW'(32767))
			ctl = 16'sh7FFF;
		else if (prod < -PW'(32767))
			ctl = -16'sh7FFF;
		else
			ctl = prod[15:0];
		if (!ctrl_r[`CAP_B_PROF])
		begin
			if (ctl > lim)
				ctl = lim;
			else if (ctl < -lim)
				ctl = -lim;
		end
	end

	// sequence state machine
	cap_state_t st_r;
	logic signed [15:0] dem_r;
	logic jog_any, moving;
	logic [POS_W-1:0] step;
	assign jog_any = sw_s_r.jog_pos ^ sw_s_r.jog_neg;
	assign moving = (dem_r != 16'sh0000);
	assign step = POS_W'(spd_f);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r <= ST_OFF;
			tgt_r <= '0;
		end
		else if (tick && !sw_s_r.enable)
			st_r <= ST_OFF;
		else if (tick)
			case (st_r)
				ST_OFF:
				begin
					st_r <= ST_HOLD;
					tgt_r <= act_r;
				end
				ST_HOLD:
					if (sw_s_r.start)
						st_r <= ST_RUN;
					else if (jog_any)
						st_r <= ST_JOG;
				ST_JOG:
					if (sw_s_r.start || !jog_any)
					begin
						st_r <= ST_HOLD;
						tgt_r <= act_r;
					end
				ST_RUN:
					if (!sw_s_r.start)
					begin
						st_r <= ST_HOLD;
						if (!moving)
							tgt_r <= act_r;
						else if (dem_r > 16'sh0000)
							tgt_r <= act_r + estr_r[POS_W-1:0];
						else
							tgt_r <= act_r - estr_r[POS_W-1:0];
					end
					else if (!ctrl_r[`CAP_B_PROF])
						tgt_r <= cmd_pos;
					else if (tgt_r + step < cmd_pos)
						tgt_r <= tgt_r + step;
					else if (tgt_r > cmd_pos + step)
						tgt_r <= tgt_r - step;
					else
						tgt_r <= cmd_pos;
				default: st_r <= ST_OFF;
			endcase
	end

	// raw demand per state
	always_comb
	begin
		case (st_r)
			ST_JOG: raw = sw_s_r.jog_pos ? $signed(jogv_r[15:0]) :
				-$signed(jogv_r[15:0]);
			ST_HOLD, ST_RUN: raw = ctl;
			default: raw = 16'sh0000;
		endcase
	end

	// first-order lag on the demand
	logic signed [16:0] dlt;
	assign dlt = (17'(raw) - 17'(dem_r)) >>> gain_r[`CAP_F_FSH];
	always_ff @(posedge clk_i)
	begin
		if (rst_i || st_r == ST_OFF)
			dem_r <= '0;
		else if (tick)
			dem_r <= dem_r + dlt[15:0];
	end

	// output stage: fault value, polarity, voltage or current code
	logic fault;
	logic signed [15:0] odem;
	assign fault = !sw_s_r.enable || sens_err_r ||
		(st_r == ST_RUN && cmd_err_r);
	always_comb
	begin
		if (fault && ctrl_r[`CAP_B_FLT_EN])
			odem = $signed(fval_r[15:0]);
		else if (st_r == ST_OFF || fault)
			odem = 16'sh0000;
		else
			odem = dem_r;
		if (ctrl_r[`CAP_B_OUT_INV])
			odem = -odem;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			aout_o <= '0;
		else
		begin
			aout_o.dac <= ctrl_r[`CAP_B_OUT_CUR] ?
				{~odem[15], odem[14:0]} : odem;
			aout_o.current <= ctrl_r[`CAP_B_OUT_CUR];
			aout_o.enable <= sw_s_r.enable ||
				(fault && ctrl_r[`CAP_B_FLT_EN]);
			aout_o.monitor <= 16'(act_r >> gain_r[`CAP_F_MSH]);
		end
	end

	// status outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ready_o <= 1'b0;
			inpos_o <= 1'b0;
		end
		else
		begin
			ready_o <= sw_s_r.enable && !sens_err_r;
			inpos_o <= sw_s_r.start && st_r == ST_RUN &&
				abs_cerr <= EW'(win_r);
		end
	end

	// bus answer and read mux
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
			case (wb_adr_i)
				`CAP_OFF_CTRL: wb_dat_o <= ctrl_r;
				`CAP_OFF_WIN: wb_dat_o <= win_r;
				`CAP_OFF_ESTR: wb_dat_o <= estr_r;
				`CAP_OFF_JOGV: wb_dat_o <= jogv_r;
				`CAP_OFF_FVAL: wb_dat_o <= fval_r;
				`CAP_OFF_SSI: wb_dat_o <= ssi_r;
				`CAP_OFF_GAIN: wb_dat_o <= gain_r;
				`CAP_OFF_STRK: wb_dat_o <= strk_r;
				`CAP_OFF_BRK: wb_dat_o <= brk_r;
				`CAP_OFF_STAT: wb_dat_o <= {25'h0, 2'(st_r), cmd_err_r,
					sens_err_r, fault, inpos_o, ready_o};
				`CAP_OFF_POS: wb_dat_o <= 32'(act_r);
				`CAP_OFF_DEM: wb_dat_o <= 32'(dem_r);
				default: wb_dat_o <= '0;
			endcase
		end
	end
	assign wb_ack_o = ack_r;

	// checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ready_cause_a: assert property (
		ready_o |-> $past(sw_s_r.enable) && !$past(sens_err_r))
		else $error("ready without enable or with sensor fault");
	inpos_win_a: assert property (
		$past(abs_cerr) > EW'($past(win_r)) |-> !inpos_o)
		else $error("in-position outside window");
	inpos_start_a: assert property (
		!$past(sw_s_r.start) |-> !inpos_o)
		else $error("in-position with start off");
	jog_dem_a: assert property (
		st_r == ST_JOG && sw_s_r.jog_pos |-> raw == $signed(jogv_r[15:0]))
		else $error("jog demand not jog speed");
	jog_rel_a: assert property (
		$past(st_r) == ST_JOG && st_r == ST_HOLD |-> tgt_r == $past(act_r))
		else $error("jog release did not capture actual");
	run_tgt_a: assert property (
		tick && st_r == ST_RUN && sw_s_r.start && sw_s_r.enable &&
		!ctrl_r[`CAP_B_PROF] |=> tgt_r == $past(cmd_pos))
		else $error("run target not command");
	enable_init_a: assert property (
		$past(st_r) == ST_OFF && st_r == ST_HOLD |-> tgt_r == $past(act_r))
		else $error("enable did not copy actual");
	enable_first_a: assert property (
		tick && !sw_s_r.enable |=> st_r == ST_OFF ##1 aout_o.dac ==
		((ctrl_r[`CAP_B_FLT_EN] ? $past(odem) : 16'h0000) ^
		{$past(ctrl_r[`CAP_B_OUT_CUR]), 15'h0000}))
		else $error("enable loss not honoured");
	stop_stroke_a: assert property (
		$past(st_r) == ST_RUN && st_r == ST_HOLD && $past(moving) |->
		tgt_r == ($past(dem_r) > 16'sh0000 ?
		$past(act_r) + $past(estr_r[POS_W-1:0]) :
		$past(act_r) - $past(estr_r[POS_W-1:0])))
		else $error("stop stroke not applied");
	ssi_half_a: assert property (
		$fell(ssi_clk_o) |-> !ssi_clk_o [*8])
		else $error("sensor clock low phase too short");
	cover property (st_r == ST_JOG ##1 st_r == ST_HOLD);
	cover property (st_r == ST_RUN && inpos_o);
	cover property ($past(st_r) == ST_RUN && st_r == ST_HOLD && moving);
	cover property (fault && aout_o.enable);
endmodule
`default_nettype wire

// ===== tb/cap_ssi_sensor.sv
// absolute position sensor model on a synchronous serial link
// assumes the master clock idles high; data idles high between frames
`timescale 1ns/1ps
`default_nettype none
module cap_ssi_sensor #(
	parameter int NBITS = 6,
	parameter int MONO_NS = 4500
) (
	// link
	input wire logic ssi_clk_i,
	output logic ssi_dat_o,
	// position and behaviour
	input wire logic [23:0] pos_i,
	input wire logic gray_i,
	input wire logic fault_i
);
	logic dat_r;
	logic done_r;
	logic [23:0] sh_r;
	// a broken sensor leaves the line low
	assign ssi_dat_o = fault_i ? 1'b0 : dat_r;
	// latch on first fall, shift msb first on each rise
	initial
	begin
		dat_r = 1'b1;
		forever
		begin
			@(negedge ssi_clk_i);
			sh_r = gray_i ? pos_i ^ (pos_i >> 1) : pos_i;
			sh_r = sh_r << (24 - NBITS);
			for (int k = 0; k < NBITS; k++)
			begin
				@(posedge ssi_clk_i);
				dat_r = sh_r[23];
				sh_r = sh_r << 1;
			end
			@(posedge ssi_clk_i);
			dat_r = 1'b0;
			done_r = 1'b0;
			// monoflop: low until the clock rests high long enough
			while (!done_r)
			begin
				fork
					#(MONO_NS);
					@(negedge ssi_clk_i);
				join_any
				disable fork;
				if (ssi_clk_i)
					done_r = 1'b1;
				else
					@(posedge ssi_clk_i);
			end
			dat_r = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the axis positioner
// assumes cap_consts.svh on the include path and the sensor model
`timescale 1ns/1ps
`default_nettype none
`include "cap_consts.svh"
module testbench;
	import cap_pkg::*;
	localparam int CYC = 2900;
	localparam logic [7:0] NOMAP = 8'h40;
	typedef struct {
		string name;
		logic [31:0] exp;
		logic [31:0] mask;
	} cap_note_t;
	logic clk_i;
	logic rst_i;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i;
	logic ssi_clk_o, ssi_dat_i, ready_o, inpos_o, gray, flt;
	logic [31:0] lfsr_r = 32'h3EC6;
	cap_sw_t sw_i;
	cap_adc_t adc_i;
	cap_aout_t aout_o;
	cap_note_t notes[$];
	int error_cnt = 0;
	int comparisons = 0;

	// clock
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	cap_axis_top #(.CTRL_CYC(CYC), .POS_W(24)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .sw_i(sw_i), .adc_i(adc_i),
		.ssi_clk_o(ssi_clk_o), .ssi_dat_i(ssi_dat_i), .aout_o(aout_o),
		.ready_o(ready_o), .inpos_o(inpos_o));

	cap_ssi_sensor #(.NBITS(6), .MONO_NS(4500)) i_sensor (
		.ssi_clk_i(ssi_clk_o), .ssi_dat_o(ssi_dat_i), .pos_i(24'h00002D),
		.gray_i(gray), .fault_i(flt));

	function automatic logic [31:0] rnd();
		lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		return lfsr_r;
	endfunction

	task automatic fail(input string what, input logic [31:0] e,
		input logic [31:0] g);
		error_cnt++;
		$display("FAIL %s expected %h seen %h", what, e, g);
	endtask

	// pin value compared at once
	task automatic chk_pin(input string what, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e)
			fail(what, e, g);
	endtask

	// read answer compared under its mask
	task automatic chk_rd(input cap_note_t nt);
		comparisons++;
		if (((wb_dat_o ^ nt.exp) & nt.mask) !== 32'h0)
			fail(nt.name, nt.exp, wb_dat_o);
	endtask

	// classic single cycle, held until ack is sampled
	task automatic wb_xfer(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		// only the watchdog ends a wait that never sees ack
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_xfer(1'b1, a, d, 4'hF);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, input string what);
		cap_note_t nt;
		nt.name = what;
		nt.exp = e;
		nt.mask = m;
		notes.push_back(nt);
		wb_xfer(1'b0, a, 32'h0, 4'hF);
	endtask

	task automatic ticks(input int n);
		repeat (n * CYC + 10) @(posedge clk_i);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// read monitor: oldest note against each read answer
	always @(posedge clk_i)
	begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0)
			chk_rd(notes.pop_front());
	end

	// watchdog
	initial
	begin
		repeat (95000) @(posedge clk_i);
		fail("watchdog", 32'h0, 32'h1);
		end_of_test();
	end

	// main sequence
	initial
	begin
		logic [31:0] r;
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h0;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		sw_i = '0;
		adc_i = '0;
		gray = 1'b0;
		flt = 1'b0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		r = rnd();
		adc_i.speed_cmd <= r[11:0];
		chk_pin("ready", 32'h0, {31'h0, ready_o});
		chk_pin("out enable", 32'h0, {31'h0, aout_o.enable});
		rd(`CAP_OFF_CTRL, `CAP_RST_CTRL, '1, "ctrl");
		rd(`CAP_OFF_WIN, `CAP_RST_WIN, '1, "win");
		rd(`CAP_OFF_ESTR, `CAP_RST_ESTR, '1, "estr");
		rd(`CAP_OFF_JOGV, `CAP_RST_JOGV, '1, "jogv");
		rd(`CAP_OFF_FVAL, `CAP_RST_FVAL, '1, "fval");
		rd(`CAP_OFF_SSI, `CAP_RST_SSI, '1, "ssi");
		rd(`CAP_OFF_GAIN, `CAP_RST_GAIN, '1, "gain");
		rd(`CAP_OFF_STRK, `CAP_RST_STRK, '1, "stroke");
		rd(`CAP_OFF_BRK, `CAP_RST_BRK, '1, "brake");
		wr(NOMAP, rnd());
		rd(NOMAP, 32'h0, '1, "unmapped");
		wr(`CAP_OFF_STAT, 32'hFFFF_FFFF);
		rd(`CAP_OFF_STAT, 32'h0, 32'h63, "status");
		r = rnd();
		wr(`CAP_OFF_FVAL, r);
		wb_xfer(1'b1, `CAP_OFF_FVAL, ~r, 4'h1);
		rd(`CAP_OFF_FVAL, {16'h0, r[15:8], ~r[7:0]}, 32'hFFFF, "lanes");
		for (int c = 0; c < 3; c++)
		begin
			wr(`CAP_OFF_CTRL, 32'h40 | (c << 4));
			rd(`CAP_OFF_CTRL, 32'h40 | (c << 4), '1, "curve");
		end
		$display("test registers done");
		// serial position, then gray code at two micrometres a step
		wr(`CAP_OFF_WIN, 32'h14);
		wr(`CAP_OFF_STRK, 32'hFFF);
		wr(`CAP_OFF_FVAL, 32'h1234);
		wr(`CAP_OFF_CTRL, 32'h50);
		wr(`CAP_OFF_SSI, 32'h0001_0006);
		ticks(2);
		rd(`CAP_OFF_POS, 32'h2D, '1, "position");
		gray <= 1'b1;
		wr(`CAP_OFF_SSI, 32'h0002_0106);
		ticks(2);
		rd(`CAP_OFF_POS, 32'h5A, '1, "gray position");
		gray <= 1'b0;
		wr(`CAP_OFF_SSI, 32'h0001_0006);
		$display("test serial done");
		sw_i.enable <= 1'b1;
		ticks(2);
		chk_pin("ready", 32'h1, {31'h0, ready_o});
		chk_pin("out enable", 32'h1, {31'h0, aout_o.enable});
		rd(`CAP_OFF_STAT, 32'h21, 32'h6B, "hold");
		$display("test enable done");
		// jog with start off; the far side never jogs with start on
		sw_i.jog_pos <= 1'b1;
		ticks(3);
		rd(`CAP_OFF_STAT, 32'h41, 32'h61, "jog state");
		chk_pin("jog sign", 32'h0, {30'h0, aout_o.dac[15], aout_o.dac == 16'h0});
		sw_i.jog_pos <= 1'b0;
		ticks(1);
		rd(`CAP_OFF_STAT, 32'h21, 32'h61, "jog release");
		wr(`CAP_OFF_CTRL, 32'h54);
		sw_i.jog_pos <= 1'b1;
		ticks(3);
		chk_pin("inverted", 32'h2, {30'h0, aout_o.dac[15], aout_o.dac == 16'h0});
		wr(`CAP_OFF_CTRL, 32'h56);
		ticks(1);
		chk_pin("current", 32'h2, {30'h0, aout_o.current, aout_o.dac[15]});
		sw_i.jog_pos <= 1'b0;
		wr(`CAP_OFF_CTRL, 32'h50);
		$display("test jog done");
		adc_i.pos_cmd <= 12'h02D;
		sw_i.start <= 1'b1;
		ticks(2);
		rd(`CAP_OFF_STAT, 32'h63, 32'h63, "run");
		adc_i.pos_cmd <= 12'h064;
		ticks(1);
		chk_pin("inpos far", 32'h0, {31'h0, inpos_o});
		adc_i.pos_cmd <= 12'h02D;
		ticks(1);
		chk_pin("inpos near", 32'h1, {31'h0, inpos_o});
		sw_i.start <= 1'b0;
		ticks(1);
		chk_pin("inpos stopped", 32'h0, {31'h0, inpos_o});
		rd(`CAP_OFF_STAT, 32'h20, 32'h60, "stop");
		$display("test position done");
		flt <= 1'b1;
		ticks(2);
		chk_pin("ready fault", 32'h0, {31'h0, ready_o});
		chk_pin("fault out", 32'h1234, {16'h0, aout_o.dac});
		rd(`CAP_OFF_STAT, 32'h08, 32'h09, "sensor err");
		flt <= 1'b0;
		ticks(2);
		chk_pin("ready back", 32'h1, {31'h0, ready_o});
		wr(`CAP_OFF_CTRL, 32'hD0);
		adc_i.pos_cmd <= 12'h100;
		sw_i.start <= 1'b1;
		ticks(2);
		rd(`CAP_OFF_STAT, 32'h10, 32'h10, "cable break");
		chk_pin("break out", 32'h1234, {16'h0, aout_o.dac});
		wr(`CAP_OFF_CTRL, 32'h50);
		adc_i.pos_cmd <= 12'h02D;
		sw_i.enable <= 1'b0;
		ticks(1);
		chk_pin("ready off", 32'h0, {31'h0, ready_o});
		rd(`CAP_OFF_STAT, 32'h0, 32'h60, "off");
		$display("test faults done");
		sw_i.start <= 1'b0;
		sw_i.enable <= 1'b1;
		adc_i.fb <= 12'h80C;
		wr(`CAP_OFF_CTRL, 32'h51);
		ticks(2);
		rd(`CAP_OFF_POS, 32'h80C, 32'hFFFF_FFF8, "analog fb");
		chk_pin("monitor", 32'h8, {16'h0, aout_o.monitor});
		$display("test analog done");
		end_of_test();
	end
endmodule
`default_nettype wire
